// ---- fwlisc_host.sv ----
// Host serial controller model that frames commands to the flash block
`default_nettype none

module fwlisc_host
   import fwlisc_pkg::*;
#(
   parameter int HALF = 5                 // Half sclk period in mclk cycles
) (
   input wire logic mclk_i,               // System clock
   output logic cs_n_o,                   // Chip select, low active
   output logic sclk_o,                   // Serial clock, idles low
   output logic si_o,                     // Serial data to the device
   input wire logic so_i,                 // Serial data from the device
   input wire logic so_oen_n_i            // Device drive enable, low active
);
   timeunit 1ns;
   timeprecision 1ps;

   // ================================================================
   // Idle pins: deselected, clock still, data line released
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      si_o = 1'b0;
   end

   // ================================================================
   // One framed transfer: ntx bits out, then nrx bits in
   // Clock stands still before and after the frame
   task automatic frame(input int ntx, input logic [31:0] txw,
                        input int nrx, output logic [23:0] rxw,
                        output logic drove);
      int i;
      rxw = '0;
      drove = 1'b0;
      @(posedge mclk_i);
      cs_n_o <= 1'b0;
      for (i = 0; i < ntx + nrx; i++) begin
         repeat (HALF) @(posedge mclk_i);
         sclk_o <= 1'b0;
         if (i < ntx) begin
            si_o <= txw[ntx - 1 - i];
         end else begin
            si_o <= ~si_o; // Released line toggles
         end
         repeat (HALF) @(posedge mclk_i);
         sclk_o <= 1'b1;
         // A released data line reads as the inverse of its last bit
         if (i >= ntx) begin
            rxw = {rxw[22:0], (so_oen_n_i === 1'b0) ? so_i : ~so_i};
         end
         if (so_oen_n_i === 1'b0) begin
            drove = 1'b1;
         end
      end
      repeat (HALF) @(posedge mclk_i);
      sclk_o <= 1'b0;
      repeat (HALF) @(posedge mclk_i);
      cs_n_o <= 1'b1;
      si_o <= ~si_o;
      repeat (HALF) @(posedge mclk_i);
   endtask
endmodule

`default_nettype wire

// ---- fwlisc_pkg.sv ----
// Package for the write-latch, identity and status command block
`default_nettype none

package fwlisc_pkg;

   // ================================================================
   // Command opcodes
   localparam logic [7:0] CMD_LATCH_SET = 8'h06; // write_latch_set_cmd
   localparam logic [7:0] CMD_LATCH_CLR = 8'h04; // write_latch_clear_cmd
   localparam logic [7:0] CMD_STAT_RD = 8'h05;   // status_read_cmd
   localparam logic [7:0] CMD_ID_RD = 8'h9F;     // identity_read_cmd
   localparam logic [7:0] CMD_MKR_RD = 8'h90;    // maker_device_read_cmd

   // ================================================================
   // Frame layout and status fields
   localparam int ID_BITS = 24;                  // Identity frame length
   localparam logic [1:0] ID_LAST_IDX = 2'h2;    // Third identity byte
   localparam logic [1:0] ADDR_LAST_IDX = 2'h2;  // Third address byte
   localparam logic [2:0] BIT_LAST = 3'h7;       // Last bit of a byte
   localparam int STAT_WEL_BIT = 1;              // write_enable_latch
   localparam int STAT_BUSY_BIT = 0;             // busy_flag
   localparam logic WEL_RST = 1'b0;              // Latch after power-up
   localparam logic [7:0] OUT_SR_RST = 8'h00;
   localparam int SYNC_STAGES_DEF = 2;

   // ================================================================
   // Types
   typedef struct packed {
      logic cs_n;                                // Chip select, low active
      logic sclk;                                // Serial clock
      logic si;                                  // Serial data in
   } fwlisc_pins_t;

   typedef enum logic [2:0] {
      ST_OPC,                                    // Collecting opcode
      ST_ADDR,                                   // Collecting address
      ST_DONE,                                   // Opcode-only command
      ST_ID,                                     // Identity output
      ST_MKR,                                    // Maker/device output
      ST_STAT,                                   // Status output
      ST_IGN                                     // Ignore until deselect
   } fwlisc_state_t;

endpackage

`default_nettype wire

// ---- fwlisc_sync.sv ----
// Multi-stage synchroniser for the serial pin group
`default_nettype none

module fwlisc_sync
   import fwlisc_pkg::*;
#(
   parameter int STAGES = SYNC_STAGES_DEF
) (
   input wire logic mclk_i,             // System clock
   input wire logic srst_i,             // Synchronous reset
   input wire fwlisc_pins_t d_i,        // Asynchronous pins
   output fwlisc_pins_t q_o             // Synchronised pins
);

   // ================================================================
   // Elaboration check
   if (STAGES < 2) begin : g_bad
      $error("fwlisc_sync needs at least two stages");
   end

   fwlisc_pins_t stg_q [STAGES];

   // Chain of flops; only the last stage is visible outside
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         for (int i = 0; i < STAGES; i++) begin
            stg_q[i] <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
         end
      end else begin
         stg_q[0] <= d_i;
         for (int i = 1; i < STAGES; i++) begin
            stg_q[i] <= stg_q[i-1];
         end
      end
   end

   assign q_o = stg_q[STAGES-1];

endmodule

`default_nettype wire

// ---- fwlisc_top.sv ----
// Serial flash command handler: write latch, identity and status reads
`default_nettype none

module fwlisc_top
   import fwlisc_pkg::*;
#(
   parameter int SYNC_STAGES = SYNC_STAGES_DEF,
   parameter logic [7:0] ID_MFR = 8'h5A,  // Arbitrary maker code
   parameter logic [7:0] ID_TYPE = 8'h3C, // Arbitrary memory-type code
   parameter logic [7:0] ID_DEV = 8'h11   // Arbitrary device code
) (
   input wire logic mclk_i,               // 100 MHz system clock
   input wire logic srst_i,               // Synchronous reset, high
   input wire logic cs_n_i,               // Chip select pin, low active
   input wire logic sclk_i,               // Serial clock pin
   input wire logic si_i,                 // Serial data in pin
   input wire logic busy_i,               // Program/erase/write running
   input wire logic op_done_i,            // Write-type operation done
   input wire logic [5:0] status_hi_i,    // Status bits 7..2
   output logic so_o,                     // Serial data out
   output logic so_oen_n_o,               // Low while driving so_o
   output logic wel_o                     // Write enable latch
);

   // ================================================================
   // Pin synchronisation and edge detection
   fwlisc_pins_t pins_w;
   fwlisc_pins_t pins_s;
   logic sclk_d_q;
   logic cs_d_q;
   logic rise_w;
   logic fall_w;
   logic cs_rise_w;
   logic [7:0] shift_w;
   logic [7:0] stat_w;
   fwlisc_state_t st_q;
   fwlisc_state_t st_d;

   assign pins_w = '{cs_n: cs_n_i, sclk: sclk_i, si: si_i};

   fwlisc_sync #(
      .STAGES(SYNC_STAGES)
   ) u_sync (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .d_i(pins_w),
      .q_o(pins_s)
   );

   // Previous synchronised levels for edge detection
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         sclk_d_q <= 1'b0;
         cs_d_q <= 1'b1;
      end else begin
         sclk_d_q <= pins_s.sclk;
         cs_d_q <= pins_s.cs_n;
      end
   end

   // Clock edges count only while selected
   assign rise_w = !pins_s.cs_n && pins_s.sclk && !sclk_d_q;
   assign fall_w = !pins_s.cs_n && !pins_s.sclk && sclk_d_q;
   assign cs_rise_w = pins_s.cs_n && !cs_d_q;

   // ================================================================
   // Input shifting
   logic [7:0] in_sr_q;
   logic [2:0] bit_cnt_q;
   logic [1:0] byte_cnt_q;
   logic [7:0] opc_q;

   assign shift_w = {in_sr_q[6:0], pins_s.si};

   // Bit and address-byte counters, cleared by deselect
   always_ff @(posedge mclk_i) begin
      if (srst_i || pins_s.cs_n) begin
         in_sr_q <= 8'h00;
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 2'h0;
      end else if (rise_w) begin
         in_sr_q <= shift_w;
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (bit_cnt_q == BIT_LAST && st_q == ST_ADDR) begin
            byte_cnt_q <= byte_cnt_q + 2'h1;
         end
      end
   end

   // ================================================================
   // Command state machine
   logic byte_end_w;
   logic enter_w;
   logic order_q;

   assign byte_end_w = rise_w && bit_cnt_q == BIT_LAST;

   function automatic logic is_out(input fwlisc_state_t s);
      return s == ST_ID || s == ST_MKR || s == ST_STAT;
   endfunction

   // Next state from opcode, address and deselect
   always_comb begin
      st_d = st_q;
      if (pins_s.cs_n) begin
         st_d = ST_OPC;
      end else if (rise_w) begin
         case (st_q)
            ST_OPC: begin
               if (bit_cnt_q == BIT_LAST) begin
                  case (shift_w)
                     CMD_LATCH_SET: st_d = ST_DONE;
                     CMD_LATCH_CLR: st_d = ST_DONE;
                     CMD_STAT_RD: st_d = ST_STAT;
                     CMD_ID_RD: st_d = busy_i ? ST_IGN : ST_ID;
                     CMD_MKR_RD: st_d = busy_i ? ST_IGN : ST_ADDR;
                     default: st_d = ST_IGN;
                  endcase
               end
            end
            ST_ADDR: begin
               if (bit_cnt_q == BIT_LAST && byte_cnt_q == ADDR_LAST_IDX) begin
                  st_d = ST_MKR;
               end
            end
            ST_DONE: st_d = ST_IGN; // Extra bit breaks the byte boundary
            default: st_d = st_q;
         endcase
      end
   end

   assign enter_w = byte_end_w && is_out(st_d) && !is_out(st_q);

   // State, opcode and byte-order registers
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st_q <= ST_OPC;
         opc_q <= 8'h00;
         order_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (byte_end_w && st_q == ST_OPC) begin
            opc_q <= shift_w;
         end
         if (byte_end_w && st_q == ST_ADDR) begin
            order_q <= shift_w[0];
         end
      end
   end

   // ================================================================
   // Write enable latch
   logic wel_q;
   logic set_w;
   logic clr_w;

   assign set_w = cs_rise_w && st_q == ST_DONE && opc_q == CMD_LATCH_SET
                  && !busy_i;
   assign clr_w = cs_rise_w && st_q == ST_DONE && opc_q == CMD_LATCH_CLR;

   // Set wins over a completion clear in the same cycle
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wel_q <= WEL_RST;
      end else if (set_w) begin
         wel_q <= 1'b1;
      end else if (clr_w || op_done_i) begin
         wel_q <= 1'b0;
      end
   end

   assign wel_o = wel_q;

   // ================================================================
   // Output byte selection and shifting
   logic [7:0] out_sr_q;
   logic [2:0] out_cnt_q;
   logic [1:0] sel_q;
   logic so_q;
   logic oen_n_q;

   // Status byte with latch and busy in their fixed places
   always_comb begin
      stat_w = {status_hi_i, 2'h0};
      stat_w[STAT_WEL_BIT] = wel_q;
      stat_w[STAT_BUSY_BIT] = busy_i;
   end

   function automatic logic [7:0] byte_for(input fwlisc_state_t s,
                                           input logic [1:0] idx,
                                           input logic ord,
                                           input logic [7:0] stat);
      logic [7:0] r;
      r = stat;
      if (s == ST_ID) begin
         r = (idx == 2'h0) ? ID_MFR : (idx == 2'h1) ? ID_TYPE : ID_DEV;
      end else if (s == ST_MKR) begin
         r = (idx[0] ^ ord) ? ID_DEV : ID_MFR;
      end
      return r;
   endfunction

   // Load on entry, shift on falling edges, reload per byte
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         out_sr_q <= OUT_SR_RST;
         out_cnt_q <= 3'h0;
         sel_q <= 2'h0;
         so_q <= 1'b0;
      end else if (pins_s.cs_n) begin
         out_cnt_q <= 3'h0;
         sel_q <= 2'h0;
      end else if (enter_w) begin
         out_sr_q <= byte_for(st_d, 2'h0, shift_w[0], stat_w);
         out_cnt_q <= 3'h0;
         sel_q <= 2'h1;
      end else if (fall_w && is_out(st_q)) begin
         so_q <= out_sr_q[7];
         out_cnt_q <= out_cnt_q + 3'h1;
         if (out_cnt_q == BIT_LAST) begin
            out_sr_q <= byte_for(st_q, sel_q, order_q, stat_w);
            if (st_q == ST_MKR) begin
               sel_q <= {1'b0, ~sel_q[0]};
            end else if (sel_q == ID_LAST_IDX) begin
               sel_q <= 2'h0;
            end else begin
               sel_q <= sel_q + 2'h1;
            end
         end else begin
            out_sr_q <= {out_sr_q[6:0], 1'b0};
         end
      end
   end

   // Drive only in an output state while selected
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         oen_n_q <= 1'b1;
      end else begin
         oen_n_q <= !(!pins_s.cs_n && is_out(st_d));
      end
   end

   assign so_o = so_q;
   assign so_oen_n_o = oen_n_q;

   // ================================================================
   // Checks
   property p_wel_set;
      @(posedge mclk_i) disable iff (srst_i)
      set_w |=> wel_o;
   endproperty
   a_wel_set: assert property (p_wel_set)
      else $error("latch not set by set command");

   property p_wel_clr;
      @(posedge mclk_i) disable iff (srst_i)
      clr_w |=> !wel_o;
   endproperty
   a_wel_clr: assert property (p_wel_clr)
      else $error("latch not cleared by clear command");

   property p_wel_done;
      @(posedge mclk_i) disable iff (srst_i)
      (op_done_i && !set_w) |=> !wel_o;
   endproperty
   a_wel_done: assert property (p_wel_done)
      else $error("latch survived operation completion");

   property p_id_first;
      @(posedge mclk_i) disable iff (srst_i)
      (enter_w && st_d == ST_ID) |=> st_q == ST_ID && out_sr_q == ID_MFR;
   endproperty
   a_id_first: assert property (p_id_first)
      else $error("identity output did not start with maker byte");

   property p_id_second;
      @(posedge mclk_i) disable iff (srst_i)
      (fall_w && st_q == ST_ID && out_cnt_q == BIT_LAST && sel_q == 2'h1)
      |=> out_sr_q == ID_TYPE;
   endproperty
   a_id_second: assert property (p_id_second)
      else $error("memory-type byte not second");

   property p_end;
      @(posedge mclk_i) disable iff (srst_i)
      cs_rise_w |=> st_q == ST_OPC && so_oen_n_o;
   endproperty
   a_end: assert property (p_end)
      else $error("output not released at deselect");

   property p_busy_id;
      @(posedge mclk_i) disable iff (srst_i)
      (st_q == ST_OPC && byte_end_w && busy_i && shift_w == CMD_ID_RD)
      |=> st_q == ST_IGN;
   endproperty
   a_busy_id: assert property (p_busy_id)
      else $error("identity opcode decoded while busy");

   property p_stat;
      @(posedge mclk_i) disable iff (srst_i)
      (enter_w && st_d == ST_STAT) |=> st_q == ST_STAT
      && out_sr_q[1:0] == {$past(wel_q), $past(busy_i)};
   endproperty
   a_stat: assert property (p_stat)
      else $error("status byte wrong");

   property p_mkr;
      @(posedge mclk_i) disable iff (srst_i)
      (enter_w && st_d == ST_MKR)
      |=> out_sr_q == ($past(shift_w[0]) ? ID_DEV : ID_MFR);
   endproperty
   a_mkr: assert property (p_mkr)
      else $error("maker/device order wrong");

   property p_so_edge;
      @(posedge mclk_i) disable iff (srst_i)
      $changed(so_o) |-> $past(fall_w);
   endproperty
   a_so_edge: assert property (p_so_edge)
      else $error("data out changed off a falling edge");

endmodule

`default_nettype wire

// ---- tb_fwlisc_top.sv ----
// Self-checking testbench for the write latch, identity and status block
`default_nettype none

module tb_fwlisc_top;
   import fwlisc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] M_CODE = 8'h6B;  // Arbitrary maker code
   localparam logic [7:0] T_CODE = 8'h4E;  // Arbitrary memory-type code
   localparam logic [7:0] D_CODE = 8'h93;  // Arbitrary device code

   logic mclk_i, srst_i, busy_i, op_done_i;
   logic [5:0] status_hi_i, sh;
   logic cs_n, sclk, si, so_o, so_oen_n_o, wel_o, drove;
   logic [23:0] rx;
   logic [7:0] id_q[$];
   int err_total, total_checks, wel_m, i;

   // ================================================================
   // Design and host model
   fwlisc_top #(.SYNC_STAGES(2), .ID_MFR(M_CODE), .ID_TYPE(T_CODE),
                .ID_DEV(D_CODE)) fwlisc_top_inst (
      .mclk_i(mclk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sclk_i(sclk),
      .si_i(si), .busy_i(busy_i), .op_done_i(op_done_i),
      .status_hi_i(status_hi_i), .so_o(so_o), .so_oen_n_o(so_oen_n_o),
      .wel_o(wel_o));

   fwlisc_host #(.HALF(5)) fwlisc_host_inst (
      .mclk_i(mclk_i), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
      .so_i(so_o), .so_oen_n_i(so_oen_n_o));

   // ================================================================
   // Helpers
   task automatic chk(input logic [23:0] seen, input logic [23:0] want);
      total_checks++;
      if (seen !== want) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Opcode-only frame, then let the deselect settle
   task automatic cmd(input logic [7:0] op);
      fwlisc_host_inst.frame(8, {24'h0, op}, 0, rx, drove);
      repeat (8) @(posedge mclk_i);
   endtask

   // Status read with fresh random upper bits; busy level held after
   task automatic rd_status(input logic bsy);
      sh = 6'($urandom);
      @(posedge mclk_i);
      status_hi_i <= sh;
      busy_i <= bsy;
      fwlisc_host_inst.frame(8, {24'h0, CMD_STAT_RD}, 8, rx, drove);
   endtask

   // ================================================================
   // Clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   // Watchdog reckoned well above the length of the sequence
   initial begin
      repeat (40000) @(posedge mclk_i);
      err_total++;
      conclude();
   end

   // ================================================================
   // Main sequence
   initial begin
      srst_i = 1'b1;
      busy_i = 1'b0;
      op_done_i = 1'b0;
      status_hi_i = 6'h00;
      err_total = 0;
      total_checks = 0;
      id_q = {M_CODE, T_CODE, D_CODE};
      void'($urandom(84921));
      repeat (12) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      wel_m = 0;
      chk(24'(wel_o), 24'(wel_m));
      chk(24'(so_oen_n_o), 24'h000001);

      // Latch set and clear back to back, read back through status
      for (i = 0; i < 2; i++) begin
         cmd(CMD_LATCH_SET);
         wel_m = 1;
         chk(24'(wel_o), 24'(wel_m));
         rd_status(1'b0);
         chk(rx, 24'({sh, wel_m[0], 1'b0}));
         cmd(CMD_LATCH_CLR);
         wel_m = 0;
         chk(24'(wel_o), 24'(wel_m));
         rd_status(1'b0);
         chk(rx, 24'({sh, wel_m[0], 1'b0}));
      end

      // Latch set before a write-type operation, polled while busy
      cmd(CMD_LATCH_SET);
      wel_m = 1;
      rd_status(1'b1);
      chk(rx, 24'({sh, wel_m[0], 1'b1}));
      fwlisc_host_inst.frame(8, {24'h0, CMD_ID_RD}, 16, rx, drove);
      chk(24'(drove), 24'h000000);
      chk(24'(wel_o), 24'h000001);
      @(posedge mclk_i);
      op_done_i <= 1'b1;
      busy_i <= 1'b0;
      @(posedge mclk_i);
      op_done_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      wel_m = 0;
      chk(24'(wel_o), 24'(wel_m));
      rd_status(1'b0);
      chk(rx, 24'({sh, wel_m[0], 1'b0}));

      // Full identity read, maker byte first
      fwlisc_host_inst.frame(8, {24'h0, CMD_ID_RD}, ID_BITS, rx, drove);
      chk(rx, {id_q[0], id_q[1], id_q[2]});
      chk(24'(drove), 24'h000001);

      // Identity read cut short in mid-byte
      fwlisc_host_inst.frame(8, {24'h0, CMD_ID_RD}, 12, rx, drove);
      chk(rx, 24'({id_q[0], id_q[1][7:4]}));
      chk(24'(so_oen_n_o), 24'h000001);
      rd_status(1'b0);
      chk(rx, 24'({sh, wel_m[0], 1'b0}));

      // Maker/device read with both byte orders
      for (i = 0; i < 2; i++) begin
         fwlisc_host_inst.frame(32, {CMD_MKR_RD, 16'h0000, 8'(i)}, 16,
                                rx, drove);
         if (i == 0) begin
            chk(rx, 24'({id_q[0], id_q[2]}));
         end else begin
            chk(rx, 24'({id_q[2], id_q[0]}));
         end
      end
      conclude();
   end
endmodule

`default_nettype wire
